// File: src/twbil_cfg.svh
// register map, field positions and reset values of the two-wire bus block
// assumes: 32-bit AXI4-Lite words, one byte-wide register per aligned word
`ifndef TWBIL_CFG_SVH
`define TWBIL_CFG_SVH

`define TWBIL_OFS_ADDR 8'h00
`define TWBIL_OFS_FDIV 8'h04
`define TWBIL_OFS_CTL1 8'h08
`define TWBIL_OFS_STAT 8'h0C
`define TWBIL_OFS_DATA 8'h10
`define TWBIL_OFS_ACFG 8'h14

`define TWBIL_C1_EN   7
`define TWBIL_C1_IE   6
`define TWBIL_C1_MST  5
`define TWBIL_C1_TX   4
`define TWBIL_C1_TRANSMIT_ACKNOWLEDGE_SELECT 3
`define TWBIL_C1_REPEAT_START_REQUEST 2

`define TWBIL_ST_ARBITRATION_LOST_FLAG 4
`define TWBIL_ST_IF   1

`define TWBIL_AC_GCEN 7
`define TWBIL_AC_TENB 6
`define TWBIL_AC_MASK 8'hC7

`define TWBIL_RST_BYTE 8'h00
`define TWBIL_DIV_BASE 16'h0014
`define TWBIL_TEN_HDR  5'h1E
`define TWBIL_RESP_OK  2'h0
`define TWBIL_RESP_ERR 2'h2

`endif

// File: src/twbil_pkg.sv
// types shared by the two-wire bus block
// assumes: constants come from twbil_cfg.svh
package twbil_pkg;

  typedef enum logic [8:0] {
    M_IDLE  = 9'h001,
    M_START = 9'h002,
    M_WAIT  = 9'h004,
    M_LOW   = 9'h008,
    M_HIGH  = 9'h010,
    M_STPA  = 9'h020,
    M_STPB  = 9'h040,
    M_RSA   = 9'h080,
    M_RSB   = 9'h100
  } twbil_mst_e;

  typedef logic [7:0] twbil_byte_t;

endpackage : twbil_pkg

// File: src/twbil_line_mon.sv
// bus line monitor: clock edges, start and stop conditions, busy state
// assumes: line inputs already synchronous to i_mclk
`timescale 1ns/1ps
module twbil_line_mon (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda,
  output logic      o_rise,
  output logic      o_fall,
  output logic      o_start,
  output logic      o_stop,
  output logic      o_busy
);

  logic p_scl_r;
  logic p_sda_r;

  // idle bus reads high, so reset to high avoids false edges
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_scl   <= 1'b1;
      o_sda   <= 1'b1;
      p_scl_r <= 1'b1;
      p_sda_r <= 1'b1;
    end else begin
      o_scl   <= i_scl;
      o_sda   <= i_sda;
      p_scl_r <= o_scl;
      p_sda_r <= o_sda;
    end
  end

  assign o_rise  = o_scl & ~p_scl_r;
  assign o_fall  = ~o_scl & p_scl_r;
  assign o_start = o_scl & p_scl_r & p_sda_r & ~o_sda;
  assign o_stop  = o_scl & p_scl_r & ~p_sda_r & o_sda;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
    end else if (o_start) begin
      o_busy <= 1'b1;
    end else if (o_stop) begin
      o_busy <= 1'b0;
    end
  end

endmodule : twbil_line_mon

// File: src/twbil_core.sv
// two-wire bus interface: registers on AXI4-Lite, master and slave engine
// assumes: open-drain lines resolved outside; i_scl/i_sda synchronous
`timescale 1ns/1ps
`include "twbil_cfg.svh"
module twbil_core (
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_axi_awaddr,
  input  wire logic        i_axi_awvalid,
  output logic             o_axi_awready,
  input  wire logic [31:0] i_axi_wdata,
  input  wire logic [3:0]  i_axi_wstrb,
  input  wire logic        i_axi_wvalid,
  output logic             o_axi_wready,
  output logic [1:0]       o_axi_bresp,
  output logic             o_axi_bvalid,
  input  wire logic        i_axi_bready,
  input  wire logic [7:0]  i_axi_araddr,
  input  wire logic        i_axi_arvalid,
  output logic             o_axi_arready,
  output logic [31:0]      o_axi_rdata,
  output logic [1:0]       o_axi_rresp,
  output logic             o_axi_rvalid,
  input  wire logic        i_axi_rready,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_scl_o,
  output logic             o_scl_oe,
  output logic             o_sda_o,
  output logic             o_sda_oe,
  output logic             o_irq
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic twbil_mapped(input logic [7:0] a);
    case (a)
      `TWBIL_OFS_ADDR, `TWBIL_OFS_FDIV, `TWBIL_OFS_CTL1,
      `TWBIL_OFS_STAT, `TWBIL_OFS_DATA, `TWBIL_OFS_ACFG: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : twbil_mapped

  // half a line clock period in bus clocks: multiplier times divider
  function automatic logic [15:0] twbil_half(input logic [7:0] f);
    logic [15:0] d;
    d = `TWBIL_DIV_BASE + {9'h000, f[5:0], 1'b0};
    case (f[7:6])
      2'h1:    return d << 1;
      2'h2:    return d << 2;
      default: return d;
    endcase
  endfunction : twbil_half

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                 bscl;
  logic                 bsda;
  logic                 b_rise;
  logic                 b_fall;
  logic                 b_start;
  logic                 b_stop;
  logic                 busy;
  logic [7:0]           aw_r;
  logic                 awf_r;
  logic                 awf_nxt;
  logic                 wf_r;
  logic                 wf_nxt;
  logic [7:0]           wd_r;
  logic                 ws_r;
  logic                 rvalid_nxt;
  logic [31:0]          rd_mux;
  logic                 aw_hs;
  logic                 w_hs;
  logic                 ar_hs;
  logic                 wr_do;
  logic                 we;
  logic                 w_c1;
  logic                 w_st;
  logic                 w_dat;
  logic                 r_dat;
  twbil_pkg::twbil_byte_t addr_r;
  twbil_pkg::twbil_byte_t fdiv_r;
  twbil_pkg::twbil_byte_t acfg_r;
  twbil_pkg::twbil_byte_t data_r;
  twbil_pkg::twbil_byte_t sh_r;
  logic                 en_r;
  logic                 ie_r;
  logic                 mst_r;
  logic                 tx_r;
  logic                 transmit_acknowledge_select_r;
  logic                 tcf_r;
  logic                 addressed_as_slave_flag_r;
  logic                 arbitration_lost_flag_r;
  logic                 srw_r;
  logic                 iif_r;
  logic                 received_acknowledge_flag_r;
  logic [3:0]           bitcnt_r;
  logic                 addrph_r;
  logic                 ten1_r;
  logic                 ten2_r;
  logic                 slv_r;
  logic                 ackme_r;
  logic                 hold_r;
  twbil_pkg::twbil_mst_e st_r;
  twbil_pkg::twbil_mst_e st_nxt;
  logic [15:0]          cnt_r;
  logic                 mst_act;
  logic                 xmit;
  logic                 tbit;
  logic                 eval;
  logic                 adr_eval;
  logic                 gc;
  logic                 m7;
  logic                 t1;
  logic                 t2;
  logic                 hit;
  logic                 t1w;
  logic                 byte_end;
  logic                 inv;
  logic                 tcf_set;
  logic                 mst_go;
  logic                 mst_stop;
  logic                 repeat_start_request;
  logic                 arb_set;
  logic                 go;
  logic                 scl_rel;
  logic                 run;
  logic                 tick;
  logic                 m_scl_low;
  logic                 m_sda_force;
  logic                 m_sda_quiet;
  logic                 d_low;

  twbil_line_mon u_mon (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_scl   (i_scl),
    .i_sda   (i_sda),
    .o_scl   (bscl),
    .o_sda   (bsda),
    .o_rise  (b_rise),
    .o_fall  (b_fall),
    .o_start (b_start),
    .o_stop  (b_stop),
    .o_busy  (busy)
  );

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  assign aw_hs   = i_axi_awvalid & o_axi_awready;
  assign w_hs    = i_axi_wvalid & o_axi_wready;
  assign ar_hs   = i_axi_arvalid & o_axi_arready;
  assign wr_do   = awf_r & wf_r & ~o_axi_bvalid;
  assign awf_nxt = (awf_r & ~wr_do) | aw_hs;
  assign wf_nxt  = (wf_r & ~wr_do) | w_hs;
  assign rvalid_nxt = ar_hs | (o_axi_rvalid & ~i_axi_rready);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aw_r          <= `TWBIL_RST_BYTE;
      awf_r         <= 1'b0;
      o_axi_awready <= 1'b0;
      wd_r          <= `TWBIL_RST_BYTE;
      ws_r          <= 1'b0;
      wf_r          <= 1'b0;
      o_axi_wready  <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_r <= i_axi_awaddr;
      end
      if (w_hs) begin
        wd_r <= i_axi_wdata[7:0];
        ws_r <= i_axi_wstrb[0];
      end
      awf_r         <= awf_nxt;
      o_axi_awready <= ~awf_nxt;
      wf_r          <= wf_nxt;
      o_axi_wready  <= ~wf_nxt;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_axi_bvalid <= 1'b0;
      o_axi_bresp  <= `TWBIL_RESP_OK;
    end else begin
      o_axi_bvalid <= wr_do | (o_axi_bvalid & ~i_axi_bready);
      if (wr_do) begin
        o_axi_bresp <= twbil_mapped(aw_r) ? `TWBIL_RESP_OK : `TWBIL_RESP_ERR;
      end
    end
  end

  always_comb begin
    case (i_axi_araddr)
      `TWBIL_OFS_ADDR: rd_mux = {24'h000000, addr_r[7:1], 1'b0};
      `TWBIL_OFS_FDIV: rd_mux = {24'h000000, fdiv_r};
      `TWBIL_OFS_CTL1: rd_mux = {24'h000000, en_r, ie_r, mst_r, tx_r, transmit_acknowledge_select_r, 3'h0};
      `TWBIL_OFS_STAT: rd_mux = {24'h000000, tcf_r, addressed_as_slave_flag_r, busy, arbitration_lost_flag_r, 1'b0,
                                 srw_r, iif_r, received_acknowledge_flag_r};
      `TWBIL_OFS_DATA: rd_mux = {24'h000000, data_r};
      `TWBIL_OFS_ACFG: rd_mux = {24'h000000, acfg_r};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_axi_rvalid  <= 1'b0;
      o_axi_arready <= 1'b0;
      o_axi_rdata   <= 32'h00000000;
      o_axi_rresp   <= `TWBIL_RESP_OK;
    end else begin
      o_axi_rvalid  <= rvalid_nxt;
      o_axi_arready <= ~rvalid_nxt;
      if (ar_hs) begin
        o_axi_rdata <= rd_mux;
        o_axi_rresp <= twbil_mapped(i_axi_araddr) ? `TWBIL_RESP_OK : `TWBIL_RESP_ERR;
      end
    end
  end

  assign we    = wr_do & ws_r;
  assign w_c1  = we & (aw_r == `TWBIL_OFS_CTL1);
  assign w_st  = we & (aw_r == `TWBIL_OFS_STAT);
  assign w_dat = we & (aw_r == `TWBIL_OFS_DATA);
  assign r_dat = ar_hs & (i_axi_araddr == `TWBIL_OFS_DATA);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  assign mst_go   = w_c1 & wd_r[`TWBIL_C1_MST] & ~mst_r & wd_r[`TWBIL_C1_EN];
  assign mst_stop = w_c1 & ~wd_r[`TWBIL_C1_MST] & mst_r;
  assign repeat_start_request     = w_c1 & wd_r[`TWBIL_C1_REPEAT_START_REQUEST];

  // reset leaves the module disabled; it has no path to a system reset
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_r   <= 1'b0;
      ie_r   <= 1'b0;
      mst_r  <= 1'b0;
      tx_r   <= 1'b0;
      transmit_acknowledge_select_r <= 1'b0;
      addr_r <= `TWBIL_RST_BYTE;
      fdiv_r <= `TWBIL_RST_BYTE;
      acfg_r <= `TWBIL_RST_BYTE;
    end else begin
      if (w_c1) begin
        en_r   <= wd_r[`TWBIL_C1_EN];
        ie_r   <= wd_r[`TWBIL_C1_IE];
        tx_r   <= wd_r[`TWBIL_C1_TX];
        transmit_acknowledge_select_r <= wd_r[`TWBIL_C1_TRANSMIT_ACKNOWLEDGE_SELECT];
      end
      if (arb_set | (w_c1 & ~wd_r[`TWBIL_C1_EN])) begin
        mst_r <= 1'b0;
      end else if (w_c1) begin
        mst_r <= wd_r[`TWBIL_C1_MST];
      end
      if (we & (aw_r == `TWBIL_OFS_ADDR)) begin
        addr_r <= {wd_r[7:1], 1'b0};
      end
      if (we & (aw_r == `TWBIL_OFS_FDIV)) begin
        fdiv_r <= wd_r;
      end
      if (we & (aw_r == `TWBIL_OFS_ACFG)) begin
        acfg_r <= wd_r & `TWBIL_AC_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // byte engine, shared by master and slave
  // ----------------------------------------------------------------
  assign mst_act  = (st_r != twbil_pkg::M_IDLE);
  assign inv      = mst_act | slv_r;
  assign xmit     = mst_act ? (addrph_r | tx_r) : (slv_r & srw_r & ~received_acknowledge_flag_r);
  assign tbit     = data_r[3'h7 - bitcnt_r[2:0]];
  assign eval     = b_fall & (bitcnt_r == 4'h7);
  assign byte_end = b_fall & (bitcnt_r == 4'h8);
  assign adr_eval = eval & addrph_r & ~mst_act & en_r;
  assign gc       = (sh_r == 8'h00);
  assign m7       = ~acfg_r[`TWBIL_AC_TENB] & (sh_r[7:1] == addr_r[7:1]);
  assign t1       = acfg_r[`TWBIL_AC_TENB] & ~ten2_r
                    & (sh_r[7:1] == {`TWBIL_TEN_HDR, acfg_r[2:1]});
  assign t2       = ten2_r & (sh_r == {acfg_r[0], addr_r[7:1]});
  // general call answered only while enabled, in either addressing mode
  assign hit      = adr_eval & ((gc & acfg_r[`TWBIL_AC_GCEN]) | m7 | t2
                    | (t1 & sh_r[0] & ten1_r));
  assign t1w      = adr_eval & t1 & ~sh_r[0];
  assign tcf_set  = byte_end & (inv | ten2_r) & en_r;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bitcnt_r <= 4'h0;
      addrph_r <= 1'b0;
      ten1_r   <= 1'b0;
      ten2_r   <= 1'b0;
      slv_r    <= 1'b0;
      srw_r    <= 1'b0;
      sh_r     <= `TWBIL_RST_BYTE;
      ackme_r  <= 1'b0;
      received_acknowledge_flag_r   <= 1'b0;
    end else if (!en_r || b_stop) begin
      bitcnt_r <= 4'h0;
      addrph_r <= 1'b0;
      ten1_r   <= 1'b0;
      ten2_r   <= 1'b0;
      slv_r    <= 1'b0;
      ackme_r  <= 1'b0;
    end else if (b_start) begin
      bitcnt_r <= 4'hF; // the clock fall closing a start is no data bit: it wraps to zero
      addrph_r <= 1'b1;
      ten2_r   <= 1'b0;
      slv_r    <= 1'b0;
      ackme_r  <= 1'b0;
    end else begin
      if (b_rise && bitcnt_r < 4'h8) begin
        sh_r <= {sh_r[6:0], bsda};
      end
      if (b_rise && bitcnt_r == 4'h8 && xmit) begin
        received_acknowledge_flag_r <= bsda;
      end
      if (eval) begin
        bitcnt_r <= 4'h8;
        ackme_r  <= addrph_r ? (hit | t1w) : (inv & ~xmit & ~transmit_acknowledge_select_r);
        if (addrph_r) begin
          ten2_r <= t1w;
        end
        if (hit) begin
          slv_r  <= 1'b1;
          srw_r  <= (m7 | t1) & sh_r[0];
          received_acknowledge_flag_r <= 1'b0;
        end
        if (adr_eval & t2) begin
          ten1_r <= 1'b1;
        end
      end else if (byte_end) begin
        bitcnt_r <= 4'h0;
        addrph_r <= ten2_r;
        ackme_r  <= 1'b0;
      end else if (b_fall) begin
        bitcnt_r <= bitcnt_r + 4'h1;
      end
    end
  end

  // received byte, or the matched address so a general call reads zero
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_r <= `TWBIL_RST_BYTE;
    end else if (w_dat) begin
      data_r <= wd_r;
    end else if (eval & (addrph_r ? (hit | t1w) : (inv & ~xmit))) begin
      data_r <= sh_r;
    end
  end

  // slave stretches the clock after each byte until software services it
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_r <= 1'b0;
    end else if (!en_r || b_stop) begin
      hold_r <= 1'b0;
    end else if (byte_end & slv_r & ~mst_act) begin
      hold_r <= 1'b1;
    end else if (w_dat | r_dat) begin
      hold_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // arbitration and status flags
  // ----------------------------------------------------------------
  assign arb_set = en_r & (
      (mst_go & busy)
    | (repeat_start_request & ~mst_r)
    | (b_stop & mst_act & (st_r != twbil_pkg::M_STPB))
    | (b_rise & mst_act & xmit & ~bitcnt_r[3] & tbit & ~bsda)
    | (b_rise & mst_act & ~xmit & bitcnt_r[3] & ~ackme_r & ~bsda));

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tcf_r  <= 1'b0;
      addressed_as_slave_flag_r <= 1'b0;
      arbitration_lost_flag_r <= 1'b0;
      iif_r  <= 1'b0;
    end else begin
      if (tcf_set) begin
        tcf_r <= 1'b1;
      end else if (w_dat | r_dat) begin
        tcf_r <= 1'b0;
      end
      if (hit) begin
        addressed_as_slave_flag_r <= 1'b1;
      end else if (w_c1) begin
        addressed_as_slave_flag_r <= 1'b0;
      end
      if (arb_set) begin
        arbitration_lost_flag_r <= 1'b1;
      end else if (w_st & wd_r[`TWBIL_ST_ARBITRATION_LOST_FLAG]) begin
        arbitration_lost_flag_r <= 1'b0;
      end
      if (tcf_set | hit | arb_set) begin
        iif_r <= 1'b1;
      end else if (w_st & wd_r[`TWBIL_ST_IF]) begin
        iif_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // master clock generator
  // ----------------------------------------------------------------
  assign go      = w_dat | (r_dat & ~tx_r & ~addrph_r);
  assign scl_rel = (st_r == twbil_pkg::M_START) | (st_r == twbil_pkg::M_HIGH)
                 | (st_r == twbil_pkg::M_STPB) | (st_r == twbil_pkg::M_RSB);
  // a released clock only counts once the line is seen high (stretching)
  assign run     = ~scl_rel | bscl;
  assign tick    = run & (cnt_r == twbil_half(fdiv_r) - 16'h0001);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      twbil_pkg::M_IDLE:  if (mst_go & ~busy) st_nxt = twbil_pkg::M_START;
      twbil_pkg::M_START: if (tick) st_nxt = twbil_pkg::M_WAIT;
      twbil_pkg::M_WAIT: begin
        if (mst_stop) begin
          st_nxt = twbil_pkg::M_STPA;
        end else if (repeat_start_request) begin
          st_nxt = twbil_pkg::M_RSA;
        end else if (go) begin
          st_nxt = twbil_pkg::M_LOW;
        end
      end
      twbil_pkg::M_LOW:   if (tick) st_nxt = twbil_pkg::M_HIGH;
      twbil_pkg::M_HIGH: begin
        if (tick) begin
          st_nxt = bitcnt_r[3] ? twbil_pkg::M_WAIT : twbil_pkg::M_LOW;
        end
      end
      twbil_pkg::M_STPA:  if (tick) st_nxt = twbil_pkg::M_STPB;
      twbil_pkg::M_STPB:  if (tick) st_nxt = twbil_pkg::M_IDLE;
      twbil_pkg::M_RSA:   if (tick) st_nxt = twbil_pkg::M_RSB;
      twbil_pkg::M_RSB:   if (tick) st_nxt = twbil_pkg::M_START;
      default:            st_nxt = twbil_pkg::M_IDLE;
    endcase
  end

  // losing arbitration drops straight to idle: lines released, no stop
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= twbil_pkg::M_IDLE;
    end else if (!en_r || arb_set) begin
      st_r <= twbil_pkg::M_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 16'h0000;
    end else if (tick || st_nxt != st_r) begin
      cnt_r <= 16'h0000;
    end else if (run) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // line drivers
  // ----------------------------------------------------------------
  assign m_scl_low   = (st_r == twbil_pkg::M_WAIT) | (st_r == twbil_pkg::M_LOW)
                     | (st_r == twbil_pkg::M_STPA) | (st_r == twbil_pkg::M_RSA);
  assign m_sda_force = (st_r == twbil_pkg::M_START) | (st_r == twbil_pkg::M_STPA)
                     | (st_r == twbil_pkg::M_STPB);
  assign m_sda_quiet = m_sda_force | (st_r == twbil_pkg::M_RSA)
                     | (st_r == twbil_pkg::M_RSB);
  assign d_low       = bitcnt_r[3] ? ackme_r : (xmit & ~tbit);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_scl_o  <= 1'b0;
      o_sda_o  <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
      o_irq    <= 1'b0;
    end else begin
      o_scl_o  <= 1'b0;
      o_sda_o  <= 1'b0;
      o_scl_oe <= en_r & (m_scl_low | hold_r);
      o_sda_oe <= en_r & (m_sda_force | (d_low & ~m_sda_quiet));
      o_irq    <= iif_r & ie_r;
    end
  end

endmodule : twbil_core

// File: verification/twbil_core_asserts.sv
// port checker for twbil_core, bound below
// assumes one clock domain and the async active-low reset
`timescale 1ns/1ps
module twbil_core_asserts (
  input wire logic        i_mclk, i_rst_n, i_axi_awvalid, o_axi_awready,
  input wire logic        i_axi_wvalid, o_axi_wready, o_axi_bvalid, i_axi_bready,
  input wire logic        i_axi_arvalid, o_axi_arready, o_axi_rvalid, i_axi_rready,
  input wire logic        o_scl_o, o_sda_o, o_scl_oe, o_sda_oe, o_irq,
  input wire logic [7:0]  i_axi_awaddr,
  input wire logic [1:0]  o_axi_bresp,
  input wire logic [31:0] o_axi_rdata
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic wr_seen_r;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) wr_seen_r <= 1'b0;
    else if (i_axi_awvalid && o_axi_awready) wr_seen_r <= 1'b1;
  end
  sequence wr_take;
    i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready;
  endsequence
  idle_lines_a: assert property
    (!wr_seen_r |-> !o_scl_oe && !o_sda_oe && !o_irq) else $error("active before setup");
  open_drain_a: assert property (!o_scl_o && !o_sda_o) else $error("line driven high");
  wr_lat_a: assert property (wr_take |-> ##2 o_axi_bvalid) else $error("no bvalid");
  wr_err_a: assert property (wr_take ##0 (i_axi_awaddr > 8'h14) |-> ##2 o_axi_bresp == 2'h2)
    else $error("no slverr");
  b_hold_a: assert property (o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid
    && $stable(o_axi_bresp)) else $error("bresp dropped");
  rd_lat_a: assert property (i_axi_arvalid && o_axi_arready |=> o_axi_rvalid && !o_axi_arready)
    else $error("no rvalid");
  r_hold_a: assert property (o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid
    && $stable(o_axi_rdata)) else $error("rdata dropped");
  rdy_back_a: assert property ($rose(o_axi_bvalid) |-> o_axi_awready && o_axi_wready)
    else $error("ready not back");
endmodule : twbil_core_asserts
bind twbil_core twbil_core_asserts u_chk (.*);

// File: verification/twbil_peer.sv
// remote master on the two-wire bus, driven by bench tasks
// assumes pull-ups: a released line reads high
`timescale 1ns/1ps
module twbil_peer (
  input  wire logic i_mclk,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_oe = 1'b0,
  output logic      o_sda_oe = 1'b0
);
  task hw();
    repeat (30) @(posedge i_mclk);
  endtask : hw
  // a slave may stretch the clock, so wait for the line to read high
  task up();
    o_scl_oe <= 1'b0;
    for (int k = 0; k < 3000 && !i_scl; k++) @(posedge i_mclk);
    hw();
  endtask : up
  task bit_io(input logic v, output logic s);
    o_sda_oe <= !v;
    hw();
    up();
    s = i_sda;
    o_scl_oe <= 1'b1;
    hw();
  endtask : bit_io
  task send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(b[i], ack);
    bit_io(1'b1, ack);
    ack = !ack;
  endtask : send
  task start_c();
    o_sda_oe <= 1'b1;
    hw();
    o_scl_oe <= 1'b1;
    hw();
  endtask : start_c
  task stop_c();
    o_sda_oe <= 1'b1;
    hw();
    up();
    o_sda_oe <= 1'b0;
    hw();
  endtask : stop_c
endmodule : twbil_peer

// File: verification/twbil_core_tb.sv
// bench for twbil_core: AXI4-Lite software side, peer master on the lines
`timescale 1ns/1ps
module twbil_core_tb;
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00, wd = 8'h00;
  logic awr, wrd, bv, arr, rv, soe, sdoe, irq, p_soe, p_sdoe, ack;
  logic [1:0] br, rr, lr;
  logic [31:0] rd, lv;
  int err_total = 0, total_checks = 0;
  wire scl = !(soe | p_soe);
  wire sda = !(sdoe | p_sdoe);
  always #2.5 clk = !clk;
  twbil_core u_dut (.i_mclk(clk), .i_rst_n(rst_n), .i_axi_awaddr(awa), .i_axi_awvalid(awv),
    .o_axi_awready(awr), .i_axi_wdata({24'h0, wd}), .i_axi_wstrb(4'hF), .i_axi_wvalid(wv),
    .o_axi_wready(wrd), .o_axi_bresp(br), .o_axi_bvalid(bv), .i_axi_bready(bry),
    .i_axi_araddr(ara), .i_axi_arvalid(arv), .o_axi_arready(arr), .o_axi_rdata(rd),
    .o_axi_rresp(rr), .o_axi_rvalid(rv), .i_axi_rready(rry), .i_scl(scl), .i_sda(sda),
    .o_scl_o(), .o_scl_oe(soe), .o_sda_o(), .o_sda_oe(sdoe), .o_irq(irq));
  twbil_peer u_peer (.i_mclk(clk), .i_scl(scl), .i_sda(sda), .o_scl_oe(p_soe),
    .o_sda_oe(p_sdoe));
  task stop_test();
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  task lim(input int n);
    if (n >= 3000) begin
      err_total++;
      stop_test();
    end
  endtask : lim
  task wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    for (n = 0; n < 3000 && !bv; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end
    lr = br;
    bry <= 1'b0;
    @(posedge clk);
    lim(n);
  endtask : wr
  task rd_reg(input logic [7:0] a);
    int n;
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    for (n = 0; n < 3000 && !rv; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end
    lv = rd; lr = rr; rry <= 1'b0;
    @(posedge clk);
    lim(n);
  endtask : rd_reg
  task rchk(input string n, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    rd_reg(a);
    chk(n, {24'h0, e}, lv & {24'h0, m});
  endtask : rchk
  task t_reset();
    for (int k = 0; k < 24; k += 4) rchk("reset", 8'(k), 8'hFF, 8'h00);
    wr(8'h18, 8'h5A);
    chk("bresp", 32'h2, {30'h0, lr});
    rchk("unmapped", 8'h18, 8'hFF, 8'h00);
    chk("rresp", 32'h2, {30'h0, lr});
  endtask : t_reset
  task t_own();
    wr(8'h00, 8'h55);
    rchk("own", 8'h00, 8'hFF, 8'h54);
    wr(8'h08, 8'hC0);
    u_peer.start_c();
    u_peer.send(8'h54, ack);
    chk("ack", 32'h1, {31'h0, ack});
    rchk("aas", 8'h0C, 8'h46, 8'h42);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h08, 8'h80);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h0C, 8'h02);
    rchk("if", 8'h0C, 8'h02, 8'h00);
    rd_reg(8'h10);
    u_peer.stop_c();
  endtask : t_own
  task t_gcall();
    wr(8'h08, 8'hC0);
    u_peer.start_c();
    u_peer.send(8'h00, ack);
    chk("ack", 32'h0, {31'h0, ack});
    u_peer.stop_c();
    rchk("aas", 8'h0C, 8'h42, 8'h00);
    wr(8'h14, 8'h80);
    u_peer.start_c();
    u_peer.send(8'h00, ack);
    chk("ack", 32'h1, {31'h0, ack});
    rchk("aas", 8'h0C, 8'h46, 8'h42);
    rchk("data", 8'h10, 8'hFF, 8'h00);
    wr(8'h0C, 8'h02);
    u_peer.stop_c();
  endtask : t_gcall
  task t_arb();
    wr(8'h08, 8'hC4);
    rchk("arbitration_lost_flag", 8'h0C, 8'h12, 8'h12);
    wr(8'h0C, 8'h12);
    rchk("arbitration_lost_flag", 8'h0C, 8'h12, 8'h00);
    u_peer.start_c();
    wr(8'h08, 8'hE0);
    rchk("arbitration_lost_flag", 8'h0C, 8'h32, 8'h32);
    chk("sda", 32'h0, {31'h0, sdoe});
    wr(8'h0C, 8'h12);
    u_peer.stop_c();
  endtask : t_arb
  task t_mst();
    int n;
    wr(8'h04, 8'h41);
    wr(8'h08, 8'hF0);
    for (n = 0; n < 3000 && !soe; n++) @(posedge clk);
    lim(n);
    wr(8'h10, 8'hA4);
    for (n = 0; n < 3000 && soe; n++) @(posedge clk);
    lim(n);
    for (n = 0; n < 3000 && !soe; n++) @(posedge clk);
    lim(n);
    for (n = 0; n < 3000 && soe; n++) @(posedge clk);
    chk("low", 32'd44, n);
    lv = 32'h0;
    for (n = 0; n < 600 && !lv[7]; n++) rd_reg(8'h0C);
    chk("tcf", 32'h83, lv & 32'h83);
    wr(8'h0C, 8'h02);
    wr(8'h08, 8'hC0);
  endtask : t_mst
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_own();
    t_gcall();
    t_arb();
    t_mst();
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule : twbil_core_tb
